// *** ied_alu.sv ***
// Constants package and the byte/word adder with indicator generation
package ied_pkg;
    // Operation codes (instruction bits 0-4, held in word bits 15:11)
    localparam logic [4:0] OP_BYTE_IMM_ADD = 5'h00;
    localparam logic [4:0] OP_SOFT_TRAP = 5'h04;
    localparam logic [4:0] OP_PRIV_GROUP = 5'h0b;
    localparam logic [4:0] OP_PRIV_SHORT = 5'h0c;
    localparam logic [4:0] OP_PRIV_LONG = 5'h0f;
    localparam logic [4:0] OP_PCHK_GROUP = 5'h16;
    localparam logic [4:0] OP_BYTE_ADD = 5'h18;
    // Function codes
    localparam logic [2:0] FN_BYTE_ADD = 3'h6;
    localparam logic [2:0] FN_PRIV_SHORT = 3'h6;
    localparam logic [3:0] FN_G_PCHK_A = 4'h1;
    localparam logic [3:0] FN_G_PCHK_B = 4'h9;
    localparam logic [3:0] FN_G_SOFT_A = 4'h3;
    localparam logic [3:0] FN_G_SOFT_B = 4'hb;
    localparam logic [3:0] FN_G_NOP_A = 4'h2;
    localparam logic [3:0] FN_G_NOP_B = 4'h4;
    localparam logic [3:0] FN_G_NOP_C = 4'ha;
    localparam logic [3:0] FN_G_NOP_D = 4'hc;
    localparam logic [4:0] FN_LONG_A = 5'h12;
    localparam logic [4:0] FN_LONG_B = 5'h1a;
    // Addressing mode field values
    localparam logic [1:0] AM_AUTO_INC = 2'h1;
    localparam logic [1:0] AM_INDIRECT = 2'h3;
    // Instruction field positions (word bit = 15 - instruction bit)
    localparam int OP_HI = 15;
    localparam int OP_LO = 11;
    localparam int R_HI = 10;
    localparam int R_LO = 8;
    localparam int RB_HI = 7;
    localparam int RB_LO = 6;
    localparam int AM_HI = 5;
    localparam int AM_LO = 4;
    localparam int DEST_POS = 3;
    // Status word positions (status bit n sits at word bit 15 - n)
    localparam int PSW_SPEC_POS = 15;
    localparam int PSW_ISA_POS = 14;
    localparam int PSW_PRIV_POS = 13;
    localparam int PSW_IFN_POS = 11;
    localparam int PSW_STK_POS = 9;
    localparam logic [15:0] PSW_OWN_MASK = 16'hea00;
    localparam logic [15:0] PSW_RESET = 16'h0000;
    // Indicator vector positions
    localparam int IND_CARRY = 4;
    localparam int IND_OVF = 3;
    localparam int IND_EVEN = 2;
    localparam int IND_NEG = 1;
    localparam int IND_ZERO = 0;
    // Register port
    localparam logic [3:0] REG_PSW = 4'h0;
    localparam logic [3:0] REG_STORE_TOP = 4'h1;
    localparam logic [3:0] REG_OUTCOME = 4'h2;
    localparam logic [15:0] STORE_TOP_RESET = 16'hffff;
    typedef enum logic [1:0] {OUT_RUN, OUT_NOP, OUT_PCHK, OUT_SOFT} ied_outcome_t;
endpackage

module ied_alu (
    input wire logic i_byte_mode,
    input wire logic [15:0] i_a,
    input wire logic [15:0] i_b,
    output logic [15:0] o_sum,
    output logic [4:0] o_ind
);
    import ied_pkg::*;
    logic [16:0] wide;
    logic [16:0] sext;
    logic [8:0] bwide;
    logic [8:0] bsext;
    logic ovf;
    logic carry;
    logic sign;

    always_comb begin
        wide = {1'b0, i_a} + {1'b0, i_b};
        sext = {i_a[15], i_a} + {i_b[15], i_b};
        bwide = {1'b0, i_a[7:0]} + {1'b0, i_b[7:0]};
        bsext = {i_a[7], i_a[7:0]} + {i_b[7], i_b[7:0]};
        if (i_byte_mode) begin
            o_sum = {8'h00, bwide[7:0]};
            ovf = bsext[8] ^ bsext[7];
            carry = ovf ? bsext[8] : bwide[8];
            sign = bwide[7];
        end else begin
            o_sum = wide[15:0];
            ovf = sext[16] ^ sext[15];
            carry = ovf ? sext[16] : wide[16];
            sign = wide[15];
        end
        o_ind = 5'h00;
        o_ind[IND_CARRY] = carry;
        o_ind[IND_OVF] = ovf;
        o_ind[IND_EVEN] = ~o_sum[0];
        o_ind[IND_NEG] = sign;
        o_ind[IND_ZERO] = i_byte_mode ? (o_sum[7:0] == 8'h00) : (o_sum == 16'h0000);
    end
endmodule

// *** ied_decode.sv ***
// Instruction exception decoder with byte add and byte-immediate add execution

module ied_decode (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr,
    input wire logic i_supervisor,
    input wire logic i_func_illegal,
    input wire logic [15:0] i_instr_end_addr,
    input wire logic i_ea_used,
    input wire logic [15:0] i_ea,
    input wire logic i_ea_even_req,
    input wire logic i_ind_used,
    input wire logic [15:0] i_ind_addr,
    input wire logic i_svc,
    input wire logic [15:0] i_svc_lsb_ptr,
    input wire logic [15:0] i_svc_start_ptr,
    input wire logic i_stk_push,
    input wire logic i_stk_pop,
    input wire logic i_stk_store_multiple,
    input wire logic [7:0] i_stm_words,
    input wire logic [7:0] i_stack_free,
    input wire logic i_stack_full,
    input wire logic i_stack_empty,
    input wire logic [15:0] i_reg_r,
    input wire logic [7:0] i_mem_byte,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic o_done,
    output ied_pkg::ied_outcome_t o_outcome,
    output logic o_program_check,
    output logic o_soft_trap,
    output logic o_no_op,
    output logic o_base_inc,
    output logic [1:0] o_base_idx,
    output logic o_reg_we,
    output logic [2:0] o_reg_idx,
    output logic [15:0] o_reg_wdata,
    output logic o_mem_we,
    output logic [15:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    output logic o_ind_we,
    output logic [4:0] o_ind,
    output logic [15:0] o_psw,
    output logic [15:0] o_rdata
);
    import ied_pkg::*;

    function automatic logic group_priv(input logic [3:0] fn);
        group_priv = (fn == FN_G_PCHK_A) || (fn == FN_G_PCHK_B) || (fn == FN_G_SOFT_A) || (fn == FN_G_SOFT_B)
                     || (fn == FN_G_NOP_A) || (fn == FN_G_NOP_B) || (fn == FN_G_NOP_C) || (fn == FN_G_NOP_D);
    endfunction

    function automatic logic group_nop(input logic [3:0] fn);
        group_nop = (fn == FN_G_NOP_A) || (fn == FN_G_NOP_B) || (fn == FN_G_NOP_C) || (fn == FN_G_NOP_D);
    endfunction

    function automatic logic group_pchk(input logic [3:0] fn);
        group_pchk = (fn == FN_G_PCHK_A) || (fn == FN_G_PCHK_B);
    endfunction

    function automatic logic group_soft(input logic [3:0] fn);
        group_soft = (fn == FN_G_SOFT_A) || (fn == FN_G_SOFT_B);
    endfunction

    logic [4:0] op;
    logic [2:0] r_fld;
    logic [1:0] rb_fld;
    logic [1:0] am_fld;
    logic to_storage;
    logic is_byte_add;
    logic is_byte_imm;
    logic privileged;
    logic super_nop;
    logic pchk_ifn;
    logic pchk_priv;
    logic soft_ifn;
    logic bad_storage;
    logic bad_spec;
    logic bad_stack;
    logic [15:0] psw_set;
    logic [15:0] psw_clr;
    logic [15:0] psw_d;
    ied_outcome_t outcome;
    logic [15:0] alu_b;
    logic [15:0] alu_sum;
    logic [4:0] alu_ind;

    logic [15:0] psw_q;
    logic [15:0] store_top_q;
    ied_outcome_t last_q;

    assign op = i_instr[OP_HI:OP_LO];
    assign r_fld = i_instr[R_HI:R_LO];
    assign rb_fld = i_instr[RB_HI:RB_LO];
    assign am_fld = i_instr[AM_HI:AM_LO];
    assign to_storage = i_instr[DEST_POS];
    assign is_byte_add = (op == OP_BYTE_ADD) && (i_instr[2:0] == FN_BYTE_ADD);
    assign is_byte_imm = (op == OP_BYTE_IMM_ADD);

    // Privileged code set, shared by the no-operation and privilege cases
    always_comb begin
        privileged = ((op == OP_PRIV_GROUP) && group_priv(i_instr[3:0]))
                     || ((op == OP_PRIV_SHORT) && (i_instr[2:0] == FN_PRIV_SHORT))
                     || ((op == OP_PRIV_LONG) && ((i_instr[4:0] == FN_LONG_A) || (i_instr[4:0] == FN_LONG_B)));
        super_nop = i_supervisor && privileged && !(op == OP_PRIV_GROUP && !group_nop(i_instr[3:0]));
    end

    // Exception classification
    // Opcode 10110 traps in problem state and checks in supervisor state,
    // so the two tables never claim the same instruction at once
    always_comb begin
        pchk_priv = !i_supervisor && privileged;
        pchk_ifn = i_func_illegal;
        if (i_supervisor && (op == OP_PRIV_GROUP)
            && group_pchk(i_instr[3:0])) begin
            pchk_ifn = 1'b1;
        end
        if (i_supervisor && (op == OP_PCHK_GROUP)) begin
            pchk_ifn = 1'b1;
        end
        soft_ifn = (op == OP_SOFT_TRAP) || (!i_supervisor && (op == OP_PCHK_GROUP));
        if (i_supervisor && (op == OP_PRIV_GROUP)
            && group_soft(i_instr[3:0])) begin
            soft_ifn = 1'b1;
        end
        bad_storage = (i_instr_end_addr > store_top_q) || (i_ea_used && (i_ea > store_top_q));
        bad_spec = (i_ea_used && i_ea_even_req && !is_byte_add && i_ea[0])
                   || ((am_fld == AM_INDIRECT) && i_ind_used && i_ind_addr[0])
                   || (i_svc && (i_svc_lsb_ptr[0] || i_svc_start_ptr[0]));
        bad_stack = ((i_stk_push || i_stk_store_multiple) && i_stack_full)
                    || (i_stk_pop && i_stack_empty)
                    || (i_stk_store_multiple && (i_stm_words > i_stack_free));
        if (is_byte_imm) begin
            pchk_ifn = 1'b0;
            pchk_priv = 1'b0;
            bad_storage = 1'b0;
            bad_spec = 1'b0;
            soft_ifn = 1'b0;
            bad_stack = 1'b0;
        end
    end

    // Outcome and status bits, program checks ahead of soft traps
    // Only one status bit is set per instruction, the highest class wins
    // No-operation is the weakest outcome, any exception overrides it
    always_comb begin
        psw_set = 16'h0000;
        outcome = OUT_RUN;
        if (pchk_ifn || pchk_priv) begin
            outcome = OUT_PCHK;
            psw_set[PSW_IFN_POS] = pchk_ifn;
            psw_set[PSW_PRIV_POS] = pchk_priv && !pchk_ifn;
        end else if (bad_storage) begin
            outcome = OUT_PCHK;
            psw_set[PSW_ISA_POS] = 1'b1;
        end else if (bad_spec) begin
            outcome = OUT_PCHK;
            psw_set[PSW_SPEC_POS] = 1'b1;
        end else if (soft_ifn) begin
            outcome = OUT_SOFT;
            psw_set[PSW_IFN_POS] = 1'b1;
        end else if (bad_stack) begin
            outcome = OUT_SOFT;
            psw_set[PSW_STK_POS] = 1'b1;
        end else if (super_nop) begin
            outcome = OUT_NOP;
        end
        if (!i_instr_valid) begin
            psw_set = 16'h0000;
        end
    end

    // Sign-extended immediate or storage byte as second operand
    assign alu_b = is_byte_imm ? {{8{i_instr[7]}}, i_instr[7:0]} : {8'h00, i_mem_byte};

    ied_alu u_alu (
        .i_byte_mode(is_byte_add),
        .i_a(i_reg_r),
        .i_b(alu_b),
        .o_sum(alu_sum),
        .o_ind(alu_ind)
    );

    // Status word: hardware set wins over a software clear
    assign psw_clr = (i_wr && (i_addr == REG_PSW)) ? (i_wdata & PSW_OWN_MASK) : 16'h0000;

    // Next status word, shared by the register and its output copy
    assign psw_d = ((psw_q & ~psw_clr) | psw_set) & PSW_OWN_MASK;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            psw_q <= PSW_RESET;
        end else begin
            psw_q <= psw_d;
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            store_top_q <= STORE_TOP_RESET;
        end else if (i_wr && (i_addr == REG_STORE_TOP)) begin
            store_top_q <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            last_q <= OUT_RUN;
        end else if (i_instr_valid) begin
            last_q <= outcome;
        end
    end

    // Read port, data one cycle after the strobe, zero elsewhere
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            unique case (i_addr)
                REG_PSW: o_rdata <= psw_q & PSW_OWN_MASK;
                REG_STORE_TOP: o_rdata <= store_top_q;
                REG_OUTCOME: o_rdata <= {14'h0000, last_q};
                default: o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_psw <= PSW_RESET;
        end else begin
            o_psw <= psw_d;
        end
    end

    // Outcome pulses
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_done <= 1'b0;
            o_outcome <= OUT_RUN;
            o_program_check <= 1'b0;
            o_soft_trap <= 1'b0;
            o_no_op <= 1'b0;
        end else begin
            o_done <= i_instr_valid;
            o_outcome <= i_instr_valid ? outcome : OUT_RUN;
            o_program_check <= i_instr_valid && (outcome == OUT_PCHK);
            o_soft_trap <= i_instr_valid && (outcome == OUT_SOFT);
            o_no_op <= i_instr_valid && (outcome == OUT_NOP);
        end
    end

    // Base register bump with the stack trap, on the same edge
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_base_inc <= 1'b0;
            o_base_idx <= 2'h0;
        end else begin
            o_base_inc <= i_instr_valid && (outcome == OUT_SOFT) && psw_set[PSW_STK_POS]
                          && (am_fld == AM_AUTO_INC);
            o_base_idx <= rb_fld;
        end
    end

    // Result writes, only when the instruction runs
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reg_we <= 1'b0;
            o_reg_idx <= 3'h0;
            o_reg_wdata <= 16'h0000;
            o_mem_we <= 1'b0;
            o_mem_addr <= 16'h0000;
            o_mem_wdata <= 8'h00;
            o_ind_we <= 1'b0;
            o_ind <= 5'h00;
        end else begin
            o_reg_we <= 1'b0;
            o_mem_we <= 1'b0;
            o_ind_we <= 1'b0;
            o_reg_idx <= r_fld;
            o_mem_addr <= i_ea;
            o_mem_wdata <= alu_sum[7:0];
            o_ind <= alu_ind;
            if (i_instr_valid && (outcome == OUT_RUN)) begin
                if (is_byte_imm) begin
                    o_reg_we <= 1'b1;
                    o_reg_wdata <= alu_sum;
                    o_ind_we <= 1'b1;
                end else if (is_byte_add) begin
                    o_reg_we <= !to_storage;
                    o_mem_we <= to_storage;
                    o_reg_wdata <= {i_reg_r[15:8], alu_sum[7:0]};
                    o_ind_we <= 1'b1;
                end
            end
        end
    end
endmodule

// *** ied_decode_chk.sv ***
// Port-level assertion checker for the instruction exception decoder
module ied_decode_chk
import ied_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr,
    input wire logic i_supervisor,
    input wire logic i_func_illegal,
    input wire logic i_rd,
    input wire logic o_done,
    input wire ied_outcome_t o_outcome,
    input wire logic o_program_check,
    input wire logic o_soft_trap,
    input wire logic o_base_inc,
    input wire logic o_reg_we,
    input wire logic o_mem_we,
    input wire logic o_ind_we,
    input wire logic [15:0] o_psw,
    input wire logic [15:0] o_rdata
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_arst_n);
    sequence s_abi;
        i_instr_valid && i_instr[OP_HI:OP_LO] == OP_BYTE_IMM_ADD;
    endsequence
    sequence s_priv;
        i_instr_valid && !i_supervisor && !i_func_illegal && i_instr[OP_HI:OP_LO] == OP_PRIV_SHORT
            && i_instr[2:0] == FN_PRIV_SHORT;
    endsequence
    sequence s_trap;
        o_program_check || o_soft_trap;
    endsequence
    chk_done_next: assert property (i_instr_valid |=> o_done) else $error("done missing");
    chk_done_idle: assert property (!i_instr_valid |=> !o_done && o_outcome == OUT_RUN)
        else $error("stray done");
    chk_abi_clean: assert property (s_abi |=> o_reg_we && !o_program_check && !o_soft_trap)
        else $error("byte immediate add trapped");
    chk_priv_trap: assert property (s_priv |=> o_program_check && o_psw[PSW_PRIV_POS])
        else $error("privilege check missed");
    chk_trap_quiet: assert property (s_trap |-> !o_reg_we && !o_mem_we && !o_ind_we)
        else $error("suppressed op wrote");
    chk_pchk_bits: assert property (
        o_program_check |-> o_outcome == OUT_PCHK && (o_psw & 16'he800) != 16'h0000)
        else $error("program check without status bit");
    chk_soft_bits: assert property (
        o_soft_trap |-> o_outcome == OUT_SOFT && (o_psw[PSW_IFN_POS] || o_psw[PSW_STK_POS]))
        else $error("soft trap without status bit");
    chk_base_bump: assert property (o_base_inc |-> o_soft_trap && o_psw[PSW_STK_POS])
        else $error("base bump outside stack trap");
    chk_free_bits: assert property ((o_psw & ~PSW_OWN_MASK) == 16'h0000)
        else $error("unassigned status bit set");
    chk_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000) else $error("read data not idle");
endmodule

bind ied_decode ied_decode_chk chk_u (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_supervisor(i_supervisor), .i_func_illegal(i_func_illegal), .i_rd(i_rd),
    .o_done(o_done), .o_outcome(o_outcome), .o_program_check(o_program_check), .o_soft_trap(o_soft_trap),
    .o_base_inc(o_base_inc), .o_reg_we(o_reg_we), .o_mem_we(o_mem_we), .o_ind_we(o_ind_we), .o_psw(o_psw),
    .o_rdata(o_rdata));

// *** ied_store_mdl.sv ***
// Behavioural register file and byte storage facing the decoder
module ied_store_mdl (
    input wire logic i_mclk,
    input wire logic [2:0] i_ridx,
    input wire logic [15:0] i_ea,
    input wire logic i_reg_we,
    input wire logic [2:0] i_reg_idx,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_mem_we,
    input wire logic [15:0] i_mem_addr,
    input wire logic [7:0] i_mem_wdata,
    output logic [15:0] o_reg_r,
    output logic [7:0] o_mem_byte
);
    logic [15:0] regs [8];
    logic [7:0] mem [16];
    initial begin
        foreach (regs[k]) regs[k] = 16'h0000;
        foreach (mem[k]) mem[k] = 8'h00;
    end
    assign o_reg_r = regs[i_ridx];
    assign o_mem_byte = mem[i_ea[3:0]];
    always @(posedge i_mclk) begin
        if (i_reg_we) begin
            regs[i_reg_idx] <= i_reg_wdata;
        end
        if (i_mem_we) begin
            mem[i_mem_addr[3:0]] <= i_mem_wdata;
        end
    end
endmodule

// *** ied_decode_tb.sv ***
// Self-checking bench for the instruction exception decoder
module ied_decode_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ied_pkg::*;
    logic i_mclk = '0, i_arst_n = '0, i_instr_valid = '0, i_supervisor = '0, i_func_illegal = '0;
    logic i_ea_used = '0, i_ea_even_req = '0, i_ind_used = '0, i_svc = '0, i_stk_push = '0, i_stk_pop = '0;
    logic i_stk_store_multiple = '0, i_stack_full = '0, i_stack_empty = '0, i_wr = '0, i_rd = '0;
    logic [15:0] i_instr = '0, i_instr_end_addr = '0, i_ea = '0, i_ind_addr = '0, i_svc_lsb_ptr = '0;
    logic [15:0] i_svc_start_ptr = '0, i_reg_r, i_wdata = '0;
    logic [7:0] i_stm_words = '0, i_stack_free = '0, i_mem_byte;
    logic [3:0] i_addr = '0;
    logic o_done, o_program_check, o_soft_trap, o_no_op, o_base_inc, o_reg_we, o_mem_we, o_ind_we;
    ied_outcome_t o_outcome;
    logic [1:0] o_base_idx;
    logic [2:0] o_reg_idx;
    logic [15:0] o_reg_wdata, o_mem_addr, o_psw, o_rdata;
    logic [7:0] o_mem_wdata;
    logic [4:0] o_ind;
    int errors = 0, samples_checked = 0, cycles = 0;
    typedef struct packed {logic [15:0] ins; ied_outcome_t sup_out; ied_outcome_t prb_out;} ied_row_t;
    typedef struct packed {logic [15:0] ins; logic [15:0] rv; logic [7:0] mb; logic [15:0] res; logic [4:0] ind;}
        ied_alu_t;
    localparam ied_row_t CODES [13] = '{'{16'h2000, OUT_SOFT, OUT_SOFT}, '{16'hb000, OUT_PCHK, OUT_SOFT},
        '{16'h5801, OUT_PCHK, OUT_PCHK}, '{16'h5809, OUT_PCHK, OUT_PCHK}, '{16'h5803, OUT_SOFT, OUT_PCHK},
        '{16'h580b, OUT_SOFT, OUT_PCHK}, '{16'h5802, OUT_NOP, OUT_PCHK}, '{16'h5804, OUT_NOP, OUT_PCHK},
        '{16'h580a, OUT_NOP, OUT_PCHK}, '{16'h580c, OUT_NOP, OUT_PCHK}, '{16'h6006, OUT_NOP, OUT_PCHK},
        '{16'h7812, OUT_NOP, OUT_PCHK}, '{16'h781a, OUT_NOP, OUT_PCHK}};
    localparam ied_alu_t ALU [4] = '{'{16'h02ff, 16'h0001, 8'h00, 16'h0000, 5'h15},
        '{16'h037f, 16'h7fff, 8'h00, 16'h807e, 5'h0e}, '{16'hc10e, 16'h12f0, 8'h20, 16'h0010, 5'h14},
        '{16'hc406, 16'hab7f, 8'h01, 16'hab80, 5'h0e}};

    ied_decode dut_u (.*);
    ied_store_mdl mdl_u (.i_mclk(i_mclk), .i_ridx(i_instr[10:8]), .i_ea(i_ea), .i_reg_we(o_reg_we),
        .i_reg_idx(o_reg_idx), .i_reg_wdata(o_reg_wdata), .i_mem_we(o_mem_we), .i_mem_addr(o_mem_addr),
        .i_mem_wdata(o_mem_wdata), .o_reg_r(i_reg_r), .o_mem_byte(i_mem_byte));

    always #20 i_mclk = ~i_mclk;

    task automatic end_sim();
        $display("Checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A stuck handshake ends the run as a failure
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            end_sim();
        end
    end

    task automatic cmp(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 cmp("rdata", o_rdata, exp);
    endtask

    // Status word is cleared by the same edge so it shows only this instruction's bits
    task automatic go(input logic [15:0] ins, input logic sup);
        i_instr <= ins;
        i_supervisor <= sup;
        i_instr_valid <= 1'b1;
        i_wr <= 1'b1;
        i_addr <= 4'h0;
        i_wdata <= 16'hffff;
    endtask

    task automatic see(input ied_outcome_t out, input logic [15:0] processor_status_word);
        @(posedge i_mclk);
        i_instr_valid <= 1'b0;
        i_wr <= 1'b0;
        i_func_illegal <= 1'b0;
        i_ea_used <= 1'b0;
        i_ind_used <= 1'b0;
        i_svc <= 1'b0;
        {i_stk_push, i_stk_pop, i_stk_store_multiple, i_stack_full, i_stack_empty} <= '0;
        #1 cmp("done", 16'(o_done), 16'h0001);
        cmp("outcome", 16'(o_outcome), 16'(out));
        cmp("psw", o_psw, processor_status_word);
        cmp("flags", {13'h0, o_program_check, o_soft_trap, o_no_op},
            {13'h0, out == OUT_PCHK, out == OUT_SOFT, out == OUT_NOP});
        if (out == OUT_PCHK || out == OUT_SOFT) cmp("quiet", {13'h0, o_reg_we, o_mem_we, o_ind_we}, 16'h0000);
    endtask

    initial begin
        repeat (5) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        i_ea_even_req <= 1'b1;
        #1 cmp("psw_rst", o_psw, 16'h0000);
        rd(4'h1, 16'hffff);
        wr(4'h5, 16'h1234);
        rd(4'h5, 16'h0000);
        rd(4'h1, 16'hffff);
        $display("reset and register port done");
        for (int k = 0; k < 26; k++) begin
            ied_row_t r;
            logic s;
            ied_outcome_t o;
            r = CODES[k % 13];
            s = k < 13;
            o = s ? r.sup_out : r.prb_out;
            @(posedge i_mclk);
            go(r.ins, s);
            see(o, o == OUT_NOP ? 16'h0000 : (o == OUT_PCHK && !s) ? 16'h2000 : 16'h0800);
        end
        for (int k = 0; k < 4; k++) begin
            ied_alu_t a;
            logic m;
            a = ALU[k];
            m = a.ins[OP_HI:OP_LO] == OP_BYTE_ADD && a.ins[DEST_POS];
            @(posedge i_mclk);
            mdl_u.regs[a.ins[R_HI:R_LO]] <= a.rv;
            mdl_u.mem[2 * k + 1] <= a.mb;
            i_ea <= 16'(2 * k + 1);
            i_ea_used <= a.ins[OP_HI:OP_LO] == OP_BYTE_ADD;
            go(a.ins, k[0]);
            see(OUT_RUN, 16'h0000);
            cmp("reg_we", 16'(o_reg_we), 16'(!m));
            cmp("mem_we", 16'(o_mem_we), 16'(m));
            cmp("reg_idx", 16'(o_reg_idx), 16'(a.ins[R_HI:R_LO]));
            cmp("mem_addr", o_mem_addr, 16'(2 * k + 1));
            cmp("result", m ? 16'(o_mem_wdata) : o_reg_wdata, a.res);
            cmp("ind", 16'(o_ind), 16'(a.ind));
        end
        $display("code table and adder rows done");
        @(posedge i_mclk);
        i_func_illegal <= 1'b1;
        i_ea_used <= 1'b1;
        i_ea <= 16'hfff1;
        go(16'h0001, 1'b0);
        see(OUT_RUN, 16'h0000);
        @(posedge i_mclk);
        i_func_illegal <= 1'b1;
        go(16'hc10e, 1'b1);
        see(OUT_PCHK, 16'h0800);
        @(posedge i_mclk);
        i_func_illegal <= 1'b1;
        go(16'h5802, 1'b0);
        see(OUT_PCHK, 16'h0800);
        wr(4'h1, 16'h00ff);
        rd(4'h1, 16'h00ff);
        @(posedge i_mclk);
        i_ea_used <= 1'b1;
        i_ea <= 16'h0100;
        go(16'hc10e, 1'b1);
        see(OUT_PCHK, 16'h4000);
        @(posedge i_mclk);
        i_instr_end_addr <= 16'h0100;
        go(16'h5802, 1'b1);
        see(OUT_PCHK, 16'h4000);
        rd(4'h2, 16'h0002);
        rd(4'h0, 16'h4000);
        wr(4'h0, 16'h4000);
        rd(4'h0, 16'h0000);
        wr(4'h1, 16'hffff);
        $display("exception priority and storage done");
        for (int k = 0; k < 4; k++) begin
            @(posedge i_mclk);
            i_ea_used <= k == 0;
            i_ea <= 16'h0011;
            i_ind_used <= k[0];
            i_ind_addr <= 16'h0021;
            i_svc <= k == 2;
            i_svc_start_ptr <= 16'h0103;
            go(k == 3 ? 16'hc13e : 16'hd030, 1'b1);
            see(OUT_PCHK, 16'h8000);
        end
        $display("specification checks done");
        for (int k = 0; k < 4; k++) begin
            @(posedge i_mclk);
            i_stk_push <= k == 0;
            i_stack_full <= k == 0;
            i_stk_pop <= k == 1;
            i_stack_empty <= k == 1;
            i_stk_store_multiple <= k > 1;
            i_stm_words <= 8'h04 + 8'(k == 2);
            i_stack_free <= 8'h04;
            go(k == 0 ? 16'hd090 : 16'hd000, 1'b1);
            see(k == 3 ? OUT_RUN : OUT_SOFT, k == 3 ? 16'h0000 : 16'h0200);
            cmp("base", {13'h0, o_base_inc, o_base_idx}, k == 0 ? 16'h0006 : 16'h0000);
        end
        $display("stack traps done");
        end_sim();
    end
endmodule
